// File: logic/addr_mode_ctrl.sv
// command interpreter for address mode, segment select, soft reset and status write enables
//
// Overview of operation
// - discovery bytes 3ch..3fh read back as e8h, 50h, f8h, a1h.
// - command b7h enters 4-byte addressing, no write enable needed.
// - segment select is 8 bits; bit 7 set means 4-byte mode, bits ignored.
// - 16h reads segment select; 17h loads it from one data byte.
// - bit 7 clear: 3-byte addresses, bits 6..0 give upper address bits.
// - command e9h leaves 4-byte addressing, no write enable needed.
// - power cycle returns the device to 3-byte addressing.
// - soft reset only on 66h immediately followed by 99h.
// - reset pair accepted on the current line width, one or four lines.
// - dedicated read command always takes a 4-byte address.
// - non-volatile status write needs a prior 06h, else rejected.
// - 50h enables a volatile status write that overrides non-volatile value.
// - 38h enters four-line mode; f5h leaves it when in four-line mode.
`timescale 1ns/1ps
`default_nettype none
module addr_mode_ctrl
	import addr_mode_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [3:0] dq_in,
	output logic [3:0] dq_out,
	output logic [3:0] dq_oe_n,
	output logic four_byte_mode,
	output logic four_line_mode,
	output logic [7:0] seg_select,
	output logic [7:0] status_active,
	output logic nv_status_write,
	output logic [7:0] nv_status,
	output logic [31:0] array_addr,
	output logic array_addr_valid,
	output logic soft_reset
);
	typedef enum logic [2:0] {
		ST_CMD,
		ST_ADDR,
		ST_DUMMY,
		ST_DATA_IN,
		ST_DATA_OUT,
		ST_IGNORE
	} phase_t;

	typedef struct packed {
		phase_t st;
		logic [7:0] cmd;
		logic [2:0] left;
		logic [31:0] addr;
		logic a4;
		logic [7:0] seg;
		logic wel;
		logic vol_wel;
		logic vol_active;
		logic [7:0] st_nv;
		logic [7:0] st_vol;
		logic quad;
		logic rst_arm;
		logic [7:0] tx_byte;
		logic tx_en;
		logic nv_wr;
		logic [31:0] aout;
		logic astb;
		logic sreset;
		logic [7:0] stat_o;
	} core_t;

	core_t q, d;
	link_if lk();

	spi_front u_front (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.sck(sck),
		.cs_n(cs_n),
		.dq_in(dq_in),
		.dq_out(dq_out),
		.dq_oe_n(dq_oe_n),
		.lk(lk)
	);

	// discovery lookup; everything outside the one dword reads as fill
	function automatic logic [7:0] disc_byte(input logic [31:0] a);
		logic [7:0] r;
		r = DISC_FILL;
		if (a[23:8] == 16'h0 && a[7:2] == DISC_BASE[7:2]) begin
			r = DISC_WORD16[8*a[1:0] +: 8];
		end
		return r;
	endfunction

	// effective status: volatile copy wins once it has been written
	function automatic logic [7:0] eff_status(input core_t s);
		return s.vol_active ? s.st_vol : s.st_nv;
	endfunction

	// byte-driven command sequencer
	always_comb begin
		d = q;
		d.nv_wr = 1'b0;
		d.astb = 1'b0;
		d.sreset = 1'b0;
		if (lk.frame_start) begin
			// every frame opens on a command byte; output is released
			d.st = ST_CMD;
			d.tx_en = 1'b0;
		end else if (lk.rx_valid) begin
			case (q.st)
				ST_CMD: begin
					d.cmd = lk.rx_byte;
					d.st = ST_IGNORE;
					// the arm survives only into the very next command
					d.rst_arm = 1'b0;
					case (lk.rx_byte)
						OP_RST_EN: begin
							d.rst_arm = 1'b1;
						end
						OP_RST: begin
							if (q.rst_arm) begin
								d.seg = SEG_RESET;
								d.wel = 1'b0;
								d.vol_wel = 1'b0;
								d.quad = 1'b0;
								d.sreset = 1'b1;
							end
						end
						OP_WREN: begin
							d.wel = 1'b1;
						end
						OP_VOL_WREN: begin
							d.vol_wel = 1'b1;
						end
						OP_ENTER_4B: begin
							d.seg[SEG_MODE_BIT] = 1'b1;
						end
						OP_EXIT_4B: begin
							d.seg[SEG_MODE_BIT] = 1'b0;
						end
						OP_ENTER_QUAD: begin
							d.quad = 1'b1;
						end
						OP_EXIT_QUAD: begin
							if (q.quad) begin
								d.quad = 1'b0;
							end
						end
						OP_RD_SEG: begin
							d.st = ST_DATA_OUT;
							d.tx_byte = q.seg;
							d.tx_en = 1'b1;
						end
						OP_RDSR: begin
							d.st = ST_DATA_OUT;
							d.tx_byte = eff_status(q);
							d.tx_en = 1'b1;
						end
						OP_WR_SEG, OP_WRSR: begin
							d.st = ST_DATA_IN;
						end
						OP_READ: begin
							// address length follows the current mode
							d.st = ST_ADDR;
							d.a4 = q.seg[SEG_MODE_BIT];
							d.left = q.seg[SEG_MODE_BIT] ? ADDR_BYTES_4B : ADDR_BYTES_3B;
						end
						OP_READ_4B: begin
							d.st = ST_ADDR;
							d.a4 = 1'b1;
							d.left = ADDR_BYTES_4B;
						end
						OP_DISC: begin
							d.st = ST_ADDR;
							d.a4 = 1'b0;
							d.left = ADDR_BYTES_3B;
						end
						default: begin
							d.st = ST_IGNORE;
						end
					endcase
				end
				ST_ADDR: begin
					d.addr = {q.addr[23:0], lk.rx_byte};
					d.left = q.left - 3'h1;
					if (q.left == 3'h1) begin
						if (q.cmd == OP_DISC) begin
							// eight dummy clocks: one byte on one line, four on four
							d.st = ST_DUMMY;
							d.left = q.quad ? DUMMY_BYTES_QUAD : DUMMY_BYTES_SPI;
						end else begin
							d.st = ST_IGNORE;
							d.astb = 1'b1;
							if (q.a4) begin
								d.aout = d.addr;
							end else begin
								d.aout = {1'b0, q.seg[6:0], d.addr[23:0]};
							end
						end
					end
				end
				ST_DUMMY: begin
					d.left = q.left - 3'h1;
					if (q.left == 3'h1) begin
						d.st = ST_DATA_OUT;
						d.tx_byte = disc_byte(q.addr);
						d.tx_en = 1'b1;
					end
				end
				ST_DATA_OUT: begin
					// discovery reads run on; register reads repeat
					if (q.cmd == OP_DISC) begin
						d.addr = q.addr + 32'h1;
						d.tx_byte = disc_byte(d.addr);
					end else if (q.cmd == OP_RD_SEG) begin
						d.tx_byte = q.seg;
					end else begin
						d.tx_byte = eff_status(q);
					end
				end
				ST_DATA_IN: begin
					d.st = ST_IGNORE;
					if (q.cmd == OP_WR_SEG) begin
						d.seg = lk.rx_byte;
					end else if (q.wel) begin
						// non-volatile write has priority over a pending volatile one
						d.st_nv = lk.rx_byte;
						d.nv_wr = 1'b1;
						d.wel = 1'b0;
					end else if (q.vol_wel) begin
						d.st_vol = lk.rx_byte;
						d.vol_active = 1'b1;
						d.vol_wel = 1'b0;
					end
				end
				default: begin
					d.st = ST_IGNORE;
				end
			endcase
		end
		d.stat_o = eff_status(d);
	end

	// reset stands for power-up; 3-byte lowest segment afterwards
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			q <= '0;
			q.st <= ST_CMD;
			q.seg <= SEG_RESET;
			q.st_nv <= STATUS_NV_RESET;
			q.st_vol <= STATUS_VOL_RESET;
			q.stat_o <= STATUS_NV_RESET;
		end else begin
			q <= d;
		end
	end

	assign lk.quad = q.quad;
	assign lk.tx_en = q.tx_en;
	assign lk.tx_byte = q.tx_byte;
	assign four_byte_mode = q.seg[SEG_MODE_BIT];
	assign four_line_mode = q.quad;
	assign seg_select = q.seg;
	assign status_active = q.stat_o;
	assign nv_status_write = q.nv_wr;
	assign nv_status = q.st_nv;
	assign array_addr = q.aout;
	assign array_addr_valid = q.astb;
	assign soft_reset = q.sreset;

	sequence cmd_byte(logic [7:0] op);
		lk.rx_valid && q.st == ST_CMD && lk.rx_byte == op;
	endsequence

	sequence data_byte(logic [7:0] op);
		lk.rx_valid && q.st == ST_DATA_IN && q.cmd == op;
	endsequence

	property p_enter_4b;
		@(posedge sys_clk) disable iff (!rstn)
		cmd_byte(OP_ENTER_4B) |=> four_byte_mode;
	endproperty
	enter_four_byte_a: assert property (p_enter_4b) else $error("b7h did not set 4-byte mode");

	property p_exit_4b;
		@(posedge sys_clk) disable iff (!rstn)
		cmd_byte(OP_EXIT_4B) |=> !four_byte_mode && seg_select[6:0] == $past(q.seg[6:0]);
	endproperty
	exit_four_byte_a: assert property (p_exit_4b) else $error("e9h did not clear 4-byte mode");

	property p_seg_write;
		@(posedge sys_clk) disable iff (!rstn)
		data_byte(OP_WR_SEG) |=> seg_select == $past(lk.rx_byte);
	endproperty
	seg_write_load_a: assert property (p_seg_write) else $error("17h data not loaded");

	property p_seg_read;
		@(posedge sys_clk) disable iff (!rstn)
		cmd_byte(OP_RD_SEG) |=> q.tx_en && q.tx_byte == $past(q.seg);
	endproperty
	seg_read_data_a: assert property (p_seg_read) else $error("16h returned wrong byte");

	property p_addr_3b;
		@(posedge sys_clk) disable iff (!rstn)
		(array_addr_valid && !q.a4) |-> array_addr[31:24] == {1'b0, seg_select[6:0]};
	endproperty
	addr_segment_a: assert property (p_addr_3b) else $error("segment bits not applied");

	property p_addr_4b;
		@(posedge sys_clk) disable iff (!rstn)
		(array_addr_valid && q.a4) |-> array_addr == q.addr;
	endproperty
	addr_full_four_a: assert property (p_addr_4b) else $error("4-byte address altered");

	property p_read_4b;
		@(posedge sys_clk) disable iff (!rstn)
		cmd_byte(OP_READ_4B) |=> q.st == ST_ADDR && q.a4 && q.left == 3'h4;
	endproperty
	dedicated_four_a: assert property (p_read_4b) else $error("13h not 4-byte addressed");

	property p_reset_pair;
		@(posedge sys_clk) disable iff (!rstn)
		soft_reset |-> $past(q.rst_arm) && $past(lk.rx_byte) == OP_RST && $past(q.st) == ST_CMD;
	endproperty
	reset_pair_only_a: assert property (p_reset_pair) else $error("reset without 66h then 99h");

	property p_reset_clear;
		@(posedge sys_clk) disable iff (!rstn)
		q.rst_arm ##0 cmd_byte(OP_RST) |=> soft_reset && seg_select == 8'h00 && !four_line_mode;
	endproperty
	reset_clears_seg_a: assert property (p_reset_clear) else $error("soft reset left state");

	property p_nv_guard;
		@(posedge sys_clk) disable iff (!rstn)
		nv_status_write |-> $past(q.wel) && !q.wel && nv_status == $past(lk.rx_byte);
	endproperty
	nv_write_guard_a: assert property (p_nv_guard) else $error("nv write without 06h");

	property p_vol_write;
		@(posedge sys_clk) disable iff (!rstn)
		(data_byte(OP_WRSR) ##0 (!q.wel && q.vol_wel)) |=> ##1 status_active == $past(lk.rx_byte, 2);
	endproperty
	vol_status_over_a: assert property (p_vol_write) else $error("volatile status not active");

	property p_quad_exit;
		@(posedge sys_clk) disable iff (!rstn)
		q.quad ##0 cmd_byte(OP_EXIT_QUAD) |=> !four_line_mode;
	endproperty
	quad_mode_exit_a: assert property (p_quad_exit) else $error("f5h did not leave quad");

	property p_disc;
		@(posedge sys_clk) disable iff (!rstn)
		(q.st == ST_DATA_OUT && q.cmd == OP_DISC && q.addr[23:0] == 24'h00003f)
			|-> q.tx_byte == 8'ha1;
	endproperty
	disc_last_byte_a: assert property (p_disc) else $error("discovery 3fh wrong");

	property p_power_up;
		@(posedge sys_clk) disable iff (!rstn)
		$rose(rstn) |-> !four_byte_mode && seg_select == 8'h00;
	endproperty
	power_up_three_a: assert property (p_power_up) else $error("not 3-byte after power-up");
endmodule
`default_nettype wire

// File: logic/addr_mode_pkg.sv
// constants shared by the address-mode and reset control block
package addr_mode_pkg;
	// command opcodes
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_READ_4B = 8'h13;
	localparam logic [7:0] OP_RD_SEG = 8'h16;
	localparam logic [7:0] OP_WR_SEG = 8'h17;
	localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
	localparam logic [7:0] OP_VOL_WREN = 8'h50;
	localparam logic [7:0] OP_DISC = 8'h5a;
	localparam logic [7:0] OP_RST_EN = 8'h66;
	localparam logic [7:0] OP_RST = 8'h99;
	localparam logic [7:0] OP_ENTER_4B = 8'hb7;
	localparam logic [7:0] OP_EXIT_4B = 8'he9;
	localparam logic [7:0] OP_EXIT_QUAD = 8'hf5;
	// segment-select layout and reset values
	localparam int SEG_MODE_BIT = 7;
	localparam logic [7:0] SEG_RESET = 8'h00;
	localparam logic [7:0] STATUS_NV_RESET = 8'h00;
	localparam logic [7:0] STATUS_VOL_RESET = 8'h00;
	// address and dummy lengths in bytes
	localparam logic [2:0] ADDR_BYTES_3B = 3'h3;
	localparam logic [2:0] ADDR_BYTES_4B = 3'h4;
	localparam logic [2:0] DUMMY_BYTES_SPI = 3'h1;
	localparam logic [2:0] DUMMY_BYTES_QUAD = 3'h4;
	// bits per sampling edge on one or four lines
	localparam logic [2:0] STEP_SPI = 3'h1;
	localparam logic [2:0] STEP_QUAD = 3'h4;
	// discovery table: 4-byte/reset/status dword at 3ch, lowest byte first
	localparam logic [7:0] DISC_BASE = 8'h3c;
	localparam logic [31:0] DISC_WORD16 = 32'ha1f850e8;
	localparam logic [7:0] DISC_FILL = 8'hff;
endpackage

// File: logic/link_if.sv
// byte-level carrier between the serial front end and the command core
`timescale 1ns/1ps
`default_nettype none
interface link_if;
	logic [7:0] rx_byte;
	logic rx_valid;
	logic frame_start;
	logic frame_end;
	logic quad;
	logic tx_en;
	logic [7:0] tx_byte;
	modport front (output rx_byte, output rx_valid, output frame_start, output frame_end,
		input quad, input tx_en, input tx_byte);
	modport core (input rx_byte, input rx_valid, input frame_start, input frame_end,
		output quad, output tx_en, output tx_byte);
endinterface
`default_nettype wire

// File: logic/spi_front.sv
// serial pin front end: synchronisers, edge finding, byte shifting on one or four lines
`timescale 1ns/1ps
`default_nettype none
module spi_front
	import addr_mode_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [3:0] dq_in,
	output logic [3:0] dq_out,
	output logic [3:0] dq_oe_n,
	link_if.front lk
);
	typedef struct packed {
		logic sck_meta;
		logic sck_sync;
		logic sck_prev;
		logic cs_meta;
		logic cs_sync;
		logic [3:0] dq_meta;
		logic [3:0] dq_sync;
		logic active;
		logic [2:0] cnt;
		logic [7:0] rx_sh;
		logic [7:0] tx_sh;
		logic [7:0] rx_byte;
		logic rx_valid;
		logic fstart;
		logic fend;
		logic [3:0] dq_out;
		logic [3:0] dq_oe_n;
	} front_t;

	front_t q, d;
	logic rise, fall;
	logic [2:0] step;

	// edges come from the second and third stages only
	assign rise = q.sck_sync & ~q.sck_prev;
	assign fall = ~q.sck_sync & q.sck_prev;
	assign step = lk.quad ? STEP_QUAD : STEP_SPI;

	// sample on rising sck, shift out on falling sck (modes 0 and 3)
	always_comb begin
		d = q;
		d.rx_valid = 1'b0;
		d.fstart = 1'b0;
		d.fend = 1'b0;
		d.sck_meta = sck;
		d.sck_sync = q.sck_meta;
		d.sck_prev = q.sck_sync;
		d.cs_meta = cs_n;
		d.cs_sync = q.cs_meta;
		d.dq_meta = dq_in;
		d.dq_sync = q.dq_meta;
		if (q.cs_sync) begin
			d.fend = q.active;
			d.active = 1'b0;
			d.dq_oe_n = 4'hf;
		end else if (!q.active) begin
			// new frame: partial bytes of the last one are dropped
			d.active = 1'b1;
			d.cnt = 3'h0;
			d.fstart = 1'b1;
			d.dq_oe_n = 4'hf;
		end else begin
			if (rise) begin
				d.rx_sh = lk.quad ? {q.rx_sh[3:0], q.dq_sync} : {q.rx_sh[6:0], q.dq_sync[0]};
				d.cnt = q.cnt + step;
				if (d.cnt == 3'h0) begin
					d.rx_byte = d.rx_sh;
					d.rx_valid = 1'b1;
				end
			end
			if (fall) begin
				if (q.cnt == 3'h0) begin
					d.tx_sh = lk.tx_byte;
				end else begin
					d.tx_sh = lk.quad ? {q.tx_sh[3:0], 4'h0} : {q.tx_sh[6:0], 1'b0};
				end
				d.dq_out = lk.quad ? d.tx_sh[7:4] : {2'h0, d.tx_sh[7], 1'b0};
				d.dq_oe_n = !lk.tx_en ? 4'hf : (lk.quad ? 4'h0 : 4'hd);
			end
		end
	end

	// one register bank; reset leaves all lines released
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			q <= '0;
			q.sck_meta <= 1'b0;
			q.cs_meta <= 1'b1;
			q.cs_sync <= 1'b1;
			q.dq_oe_n <= 4'hf;
		end else begin
			q <= d;
		end
	end

	assign dq_out = q.dq_out;
	assign dq_oe_n = q.dq_oe_n;
	assign lk.rx_byte = q.rx_byte;
	assign lk.rx_valid = q.rx_valid;
	assign lk.frame_start = q.fstart;
	assign lk.frame_end = q.fend;

	property p_quad_step;
		@(posedge sys_clk) disable iff (!rstn)
		(q.active && !q.cs_sync && rise && lk.quad) |=> (q.cnt == $past(q.cnt) + 3'h4);
	endproperty
	quad_bit_step_a: assert property (p_quad_step) else $error("quad edge did not take four bits");

	property p_release;
		@(posedge sys_clk) disable iff (!rstn)
		q.fend |-> (q.dq_oe_n == 4'hf);
	endproperty
	line_release_a: assert property (p_release) else $error("lines driven after frame end");
endmodule
`default_nettype wire

// File: test/addr_mode_ctrl_tb_top.sv
// self-checking bench for the address-mode and reset command block
`timescale 1ns/1ps
`default_nettype none
module addr_mode_ctrl_tb_top
	import addr_mode_pkg::*;
();
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic sck, cs_n, four_byte_mode, four_line_mode, nv_status_write, array_addr_valid, soft_reset;
	logic [3:0] dq_in, dq_out, dq_oe_n;
	logic [7:0] seg_select, status_active, nv_status;
	logic [31:0] array_addr, addr_seen;
	int failures = 0;
	int comparisons = 0;
	int rst_cnt = 0;
	int nvw_cnt = 0;
	int addr_cnt = 0;
	logic [7:0] disc_exp [4] = '{8'he8, 8'h50, 8'hf8, 8'ha1};

	always #10 sys_clk = ~sys_clk;

	addr_mode_ctrl i_dut (.sys_clk(sys_clk), .rstn(rstn), .sck(sck), .cs_n(cs_n),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .four_byte_mode(four_byte_mode),
		.four_line_mode(four_line_mode), .seg_select(seg_select),
		.status_active(status_active), .nv_status_write(nv_status_write),
		.nv_status(nv_status), .array_addr(array_addr),
		.array_addr_valid(array_addr_valid), .soft_reset(soft_reset));
	spi_host_model i_host (.sys_clk(sys_clk), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
		.sck(sck), .cs_n(cs_n), .dq_in(dq_in));

	// pulse counters, so a one-cycle strobe is never missed
	always @(posedge sys_clk) begin
		if (soft_reset === 1'b1) rst_cnt <= rst_cnt + 1;
		if (nv_status_write === 1'b1) nvw_cnt <= nvw_cnt + 1;
		if (array_addr_valid === 1'b1) begin
			addr_cnt <= addr_cnt + 1;
			addr_seen <= array_addr;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic t_reset_vals();
		chk(seg_select, SEG_RESET);
		chk(four_byte_mode, 1'b0);
		chk(four_line_mode, 1'b0);
		chk(dq_oe_n, 4'hf);
	endtask

	// enter and leave 4-byte mode, then a power cycle while in it
	task automatic t_four_byte();
		i_host.frame('{OP_ENTER_4B}, 0);
		chk(four_byte_mode, 1'b1);
		i_host.frame('{OP_RD_SEG, 8'h00}, 0);
		chk(i_host.rd_q[1], 8'h80);
		i_host.frame('{OP_EXIT_4B}, 0);
		chk(four_byte_mode, 1'b0);
		i_host.frame('{OP_ENTER_4B}, 0);
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk(four_byte_mode, 1'b0);
		chk(seg_select, 8'h00);
	endtask

	// segment bits feed the upper address only in 3-byte mode
	task automatic t_segment();
		int n;
		n = addr_cnt;
		i_host.frame('{OP_WR_SEG, 8'h05, 8'h77}, 0);
		chk(seg_select, 8'h05);
		i_host.frame('{OP_READ, 8'h12, 8'h34, 8'h56}, 0);
		chk(addr_seen, 32'h05123456);
		chk(addr_cnt, n + 1);
		i_host.frame('{OP_WR_SEG, 8'hc5}, 0);
		chk(four_byte_mode, 1'b1);
		i_host.frame('{OP_READ, 8'h7a, 8'hbc, 8'hde, 8'hf0}, 0);
		chk(addr_seen, 32'h7abcdef0);
		i_host.frame('{OP_WR_SEG, 8'h05}, 0);
		i_host.frame('{OP_READ_4B, 8'h01, 8'h02, 8'h03, 8'h04}, 0);
		chk(addr_seen, 32'h01020304);
	endtask

	// one dummy byte on one line, then four table bytes and one beyond
	task automatic t_discovery();
		i_host.frame('{OP_DISC, 8'h00, 8'h00, DISC_BASE, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00}, 0);
		for (int i = 0; i < 4; i++) begin
			chk(i_host.rd_q[5+i], disc_exp[i]);
		end
		chk(i_host.rd_q[9], 8'hff);
	endtask

	task automatic t_soft_reset();
		int n;
		n = rst_cnt;
		i_host.frame('{OP_RST}, 0);
		chk(rst_cnt, n);
		i_host.frame('{OP_RST_EN}, 0);
		i_host.frame('{OP_WREN}, 0);
		i_host.frame('{OP_RST}, 0);
		chk(rst_cnt, n);
		chk(seg_select, 8'h05);
		i_host.frame('{OP_RST_EN}, 0);
		i_host.frame('{OP_RST}, 0);
		chk(rst_cnt, n + 1);
		chk(seg_select, 8'h00);
	endtask

	task automatic t_status();
		int n;
		n = nvw_cnt;
		i_host.frame('{OP_WRSR, 8'haa}, 0);
		chk(nvw_cnt, n);
		chk(nv_status, 8'h00);
		i_host.frame('{OP_WREN}, 0);
		i_host.frame('{OP_WRSR, 8'haa}, 0);
		chk(nvw_cnt, n + 1);
		chk(nv_status, 8'haa);
		chk(status_active, 8'haa);
		i_host.frame('{OP_VOL_WREN}, 0);
		i_host.frame('{OP_WRSR, 8'h3c}, 0);
		chk(status_active, 8'h3c);
		chk(nv_status, 8'haa);
		chk(nvw_cnt, n + 1);
		// status read must return the volatile copy once it is active
		i_host.frame('{OP_RDSR, 8'h00}, 0);
		chk(i_host.rd_q[1], 8'h3c);
	endtask

	// four-line traffic, reset pair on four lines, exit only from four-line mode
	task automatic t_quad();
		int n;
		n = rst_cnt;
		i_host.frame('{OP_ENTER_QUAD}, 0);
		chk(four_line_mode, 1'b1);
		i_host.frame('{OP_WR_SEG, 8'h42}, 1);
		chk(seg_select, 8'h42);
		i_host.frame('{OP_RD_SEG, 8'h00}, 1);
		chk(i_host.rd_q[1], 8'h42);
		// four-line discovery read: eight dummy clocks are four bytes here
		i_host.frame('{OP_DISC, 8'h00, 8'h00, DISC_BASE, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00}, 1);
		chk(i_host.rd_q[8], disc_exp[0]);
		chk(i_host.rd_q[9], disc_exp[1]);
		i_host.frame('{OP_RST_EN}, 1);
		i_host.frame('{OP_RST}, 1);
		chk(rst_cnt, n + 1);
		chk(four_line_mode, 1'b0);
		chk(seg_select, 8'h00);
		i_host.frame('{OP_EXIT_QUAD}, 0);
		i_host.frame('{OP_ENTER_QUAD}, 0);
		chk(four_line_mode, 1'b1);
		i_host.frame('{OP_EXIT_QUAD}, 1);
		chk(four_line_mode, 1'b0);
	endtask

	// watchdog: a hung run still ends in the closing report
	initial begin
		repeat (90000) @(posedge sys_clk);
		failures++;
		wrap_up();
	end

	initial begin
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (8) @(posedge sys_clk);
		t_reset_vals();
		t_four_byte();
		t_segment();
		t_discovery();
		t_soft_reset();
		t_status();
		t_quad();
		wrap_up();
	end
endmodule
`default_nettype wire

// File: test/spi_host_model.sv
// behavioural serial host that frames commands on one or four lines
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input wire logic sys_clk,
	input wire logic [3:0] dq_out,
	input wire logic [3:0] dq_oe_n,
	output logic sck,
	output logic cs_n,
	output logic [3:0] dq_in
);
	logic [3:0] host_dq;
	logic [7:0] rd_q[$];
	// wire level: the device wins on lines it drives
	assign dq_in = (dq_oe_n & host_dq) | (~dq_oe_n & dq_out);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		host_dq = 4'h5;
	end
	// one frame, mode 0, 8 sys_clk per sck period; quad sends nibbles, high first
	task automatic frame(input logic [7:0] tx[$], input bit quad);
		logic [7:0] r;
		r = 8'h00;
		rd_q.delete();
		@(posedge sys_clk);
		cs_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		foreach (tx[k]) begin
			for (int c = 0; c < (quad ? 2 : 8); c++) begin
				// unused lines toggle so a stale level is never mistaken for data
				if (quad) begin
					host_dq <= tx[k][7-4*c -: 4];
				end else begin
					host_dq <= {~host_dq[3:1], tx[k][7-c]};
				end
				repeat (4) @(posedge sys_clk);
				sck <= 1'b1;
				repeat (4) @(posedge sys_clk);
				// sampled late in the bit: output stands until the next fall
				r = quad ? {r[3:0], dq_in} : {r[6:0], dq_in[1]};
				sck <= 1'b0;
			end
			rd_q.push_back(r);
		end
		repeat (4) @(posedge sys_clk);
		cs_n <= 1'b1; // one command per frame
		host_dq <= ~host_dq;
		repeat (16) @(posedge sys_clk);
	endtask
endmodule
`default_nettype wire
